// ===== design/uies_top.v
// Purpose: interrupt mask, source and line status logic of one UART channel
// Assumes: host strobes and datapath status are on clk_sys; two pins are synchronised
// Notes: read data appears one cycle after the read strobe
`timescale 1ns/10ps
`include "uies_defs.vh"
module uies_top (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Host register port
  input wire [2:0] busAddr,
  input wire busRd,
  input wire busWr,
  input wire [7:0] busWrData,
  input wire summarySelectN,
  output reg [7:0] busRdData,
  // Receive datapath status
  input wire [7:0] rxData,
  input wire [6:0] rxCount,
  input wire [2:0] rxHeadErr,
  input wire rxOverrun,
  input wire rxFifoErr,
  output reg rxPop,
  output reg rxFifoReset,
  // Transmit datapath status
  input wire [6:0] txCount,
  input wire thrEmpty,
  input wire tsrEmpty,
  output reg thrWrite,
  output reg [7:0] thrData,
  output reg txFifoReset,
  // Modem and flow control
  input wire [7:0] msrData,
  input wire xoffSeen,
  input wire xonSeen,
  input wire rtsN,
  input wire ctsN,
  input wire [7:0] readySummary,
  output reg msrRead,
  // Control registers out
  output reg [7:0] line_control_reg,
  output reg [7:0] modem_control_reg,
  output reg [7:0] fifo_control_reg,
  output reg [7:0] enhanced_feature_control,
  output reg [7:0] dll,
  output reg [7:0] dlm,
  output reg [7:0] divisor_fraction_reg,
  output reg [7:0] resumeCharFirst,
  output reg [7:0] resumeCharSecond,
  output reg [7:0] pauseCharFirst,
  output reg [7:0] pauseCharSecond,
  output reg sleepEnable,
  // Interrupt
  output reg irq
);

  reg [7:0] interrupt_mask;
  reg [7:0] spr;
  reg overrunFlag;
  reg txPend;
  reg txArmQ;
  reg xoffPend;
  reg flowPend;
  reg rtsNQ;
  reg ctsSync1;
  reg ctsSync2;
  reg ctsQ;
  reg selSync1;
  reg selSync2;
  reg [7:0] next_rdData;
  reg [5:0] srcCode;
  wire enh;
  wire keyed;
  wire divMap;
  wire fifoEn;
  wire [6:0] rxTrig;
  wire [6:0] txTrig;
  wire rxLevel;
  wire txCond;
  wire [7:0] line_status_reg;
  wire [7:0] effMask;
  wire lineInt;
  wire rxInt;
  wire txInt;
  wire modemInt;
  wire xoffInt;
  wire flowInt;
  wire rdLsr;
  wire rdSrc;
  wire rdMsr;
  wire wrThr;

  // Trigger level lookup
  function [6:0] trigLevel;
    input [1:0] sel;
    input isRx;
    begin
      case ({isRx, sel})
        3'h0: trigLevel = `UIES_TXT0;
        3'h1: trigLevel = `UIES_TXT1;
        3'h2: trigLevel = `UIES_TXT2;
        3'h3: trigLevel = `UIES_TXT3;
        3'h4: trigLevel = `UIES_RXT0;
        3'h5: trigLevel = `UIES_RXT1;
        3'h6: trigLevel = `UIES_RXT2;
        default: trigLevel = `UIES_RXT3;
      endcase
    end
  endfunction

  // Map selection
  assign enh = enhanced_feature_control[`UIES_EFR_ENH];
  assign keyed = (line_control_reg == `UIES_KEY);
  assign divMap = line_control_reg[`UIES_LCR_DIV] & ~keyed;
  assign fifoEn = fifo_control_reg[`UIES_FCR_EN];

  assign effMask = interrupt_mask & {{4{enh}}, 4'hF};

  assign rxTrig = trigLevel(fifo_control_reg[7:6], 1'b1);
  assign rxLevel = fifoEn ? (rxCount >= rxTrig) : (rxCount != 7'h00);
  // tx trigger, plain empty without enhanced
  assign txTrig = enh ? trigLevel(fifo_control_reg[5:4], 1'b0) : `UIES_TXT_PLAIN;
  assign txCond = fifoEn ? (txCount < txTrig) : thrEmpty;

  // Line status composition
  // data ready while FIFO holds data
  assign line_status_reg = {rxFifoErr, thrEmpty & tsrEmpty, thrEmpty, rxHeadErr, overrunFlag, rxCount != 7'h00};

  // Interrupt sources
  // line status interrupt
  assign lineInt = effMask[2] & (|line_status_reg[4:1]);
  assign rxInt = effMask[0] & rxLevel;
  assign txInt = effMask[1] & txPend;
  assign modemInt = effMask[3] & (|msrData[3:0]);
  assign xoffInt = effMask[5] & xoffPend;
  assign flowInt = flowPend;

  // Bus decode strobes
  assign rdLsr = busRd & ~keyed & (busAddr == `UIES_A_LSTAT) & selSync2;
  assign rdSrc = busRd & ~keyed & ~divMap & (busAddr == `UIES_A_SRC) & selSync2;
  assign rdMsr = busRd & ~keyed & (busAddr == `UIES_A_MSTAT) & selSync2;
  assign wrThr = busWr & ~line_control_reg[`UIES_LCR_DIV] & (busAddr == `UIES_A_DATA);

  always @* begin
    if (lineInt) begin
      srcCode = `UIES_SRC_LINE;
    end else if (rxInt) begin
      srcCode = `UIES_SRC_RX;
    end else if (txInt) begin
      srcCode = `UIES_SRC_TX;
    end else if (modemInt) begin
      srcCode = `UIES_SRC_MODEM;
    end else if (xoffInt) begin
      srcCode = `UIES_SRC_XOFF;
    end else if (flowInt) begin
      srcCode = `UIES_SRC_FLOW;
    end else begin
      srcCode = `UIES_SRC_NONE;
    end
  end

  // Read data multiplexer
  always @* begin
    next_rdData = 8'h00;
    if (!selSync2) begin
      next_rdData = readySummary;
    end else if (keyed && busAddr == `UIES_A_EFR) begin
      next_rdData = enhanced_feature_control;
    end else if (keyed && busAddr == `UIES_A_RES1) begin
      next_rdData = resumeCharFirst;
    end else if (keyed && busAddr == `UIES_A_RES2) begin
      next_rdData = resumeCharSecond;
    end else if (keyed && busAddr == `UIES_A_PAU1) begin
      next_rdData = pauseCharFirst;
    end else if (keyed && busAddr == `UIES_A_PAU2) begin
      next_rdData = pauseCharSecond;
    end else begin
      case (busAddr)
        `UIES_A_DATA: next_rdData = line_control_reg[`UIES_LCR_DIV] ? dll : rxData;
        `UIES_A_MASK: next_rdData = line_control_reg[`UIES_LCR_DIV] ? dlm : effMask;
        `UIES_A_SRC: next_rdData = divMap ? divisor_fraction_reg : {fifoEn, fifoEn, srcCode};
        `UIES_A_LCTL: next_rdData = line_control_reg;
        `UIES_A_MCTL: next_rdData = modem_control_reg;
        `UIES_A_LSTAT: next_rdData = line_status_reg;
        `UIES_A_MSTAT: next_rdData = msrData;
        default: next_rdData = spr;
      endcase
    end
  end

  // Pin synchronisers
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ctsSync1 <= 1'b1; // Idle pin level, no false edge
      ctsSync2 <= 1'b1;
      selSync1 <= 1'b1;
      selSync2 <= 1'b1;
    end else begin
      ctsSync1 <= ctsN;
      ctsSync2 <= ctsSync1;
      selSync1 <= summarySelectN;
      selSync2 <= selSync1;
    end
  end

  // Register writes and read side effects
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      interrupt_mask <= `UIES_RST8;
      line_control_reg <= `UIES_RST8;
      modem_control_reg <= `UIES_RST8;
      fifo_control_reg <= `UIES_RST8;
      enhanced_feature_control <= `UIES_RST8;
      dll <= `UIES_RST8;
      dlm <= `UIES_RST8;
      divisor_fraction_reg <= `UIES_RST8;
      spr <= `UIES_RST8;
      resumeCharFirst <= `UIES_RST8;
      resumeCharSecond <= `UIES_RST8;
      pauseCharFirst <= `UIES_RST8;
      pauseCharSecond <= `UIES_RST8;
      busRdData <= `UIES_RST8;
      thrData <= `UIES_RST8;
      thrWrite <= 1'b0;
      rxPop <= 1'b0;
      msrRead <= 1'b0;
      rxFifoReset <= 1'b0;
      txFifoReset <= 1'b0;
    end else begin
      thrWrite <= wrThr;
      rxPop <= busRd & selSync2 & ~keyed & ~line_control_reg[`UIES_LCR_DIV] & (busAddr == `UIES_A_DATA);
      msrRead <= rdMsr;
      rxFifoReset <= 1'b0;
      txFifoReset <= 1'b0;
      if (busRd) begin
        busRdData <= next_rdData;
      end
      if (wrThr) begin
        thrData <= busWrData;
      end
      if (busWr) begin
        if (keyed && busAddr == `UIES_A_EFR) begin
          enhanced_feature_control <= busWrData;
        end else if (keyed && busAddr == `UIES_A_RES1) begin
          resumeCharFirst <= busWrData;
        end else if (keyed && busAddr == `UIES_A_RES2) begin
          resumeCharSecond <= busWrData;
        end else if (keyed && busAddr == `UIES_A_PAU1) begin
          pauseCharFirst <= busWrData;
        end else if (keyed && busAddr == `UIES_A_PAU2) begin
          pauseCharSecond <= busWrData;
        end else begin
          case (busAddr)
            `UIES_A_DATA: if (line_control_reg[`UIES_LCR_DIV]) dll <= busWrData;
            `UIES_A_MASK: begin
              if (line_control_reg[`UIES_LCR_DIV]) begin
                dlm <= busWrData;
              end else begin
                interrupt_mask <= {enh ? busWrData[7:4] : interrupt_mask[7:4], busWrData[3:0]};
              end
            end
            `UIES_A_SRC: begin
              if (divMap) begin
                if (enh) divisor_fraction_reg <= busWrData;
              end else begin
                // Other bits programmed only with enable set
                fifo_control_reg[`UIES_FCR_EN] <= busWrData[`UIES_FCR_EN];
                if (busWrData[`UIES_FCR_EN]) begin
                  fifo_control_reg[7:6] <= busWrData[7:6];
                  fifo_control_reg[3] <= busWrData[3];
                  if (enh) fifo_control_reg[5:4] <= busWrData[5:4];
                  rxFifoReset <= busWrData[`UIES_FCR_RXR];
                  txFifoReset <= busWrData[`UIES_FCR_TXR];
                end
              end
            end
            `UIES_A_LCTL: line_control_reg <= busWrData;
            `UIES_A_MCTL: modem_control_reg <= {enh ? busWrData[7:5] : modem_control_reg[7:5], busWrData[4:0]};
            `UIES_A_SCR: spr <= busWrData;
            default: ;
          endcase
        end
      end
    end
  end

  // Event flags, set wins over clear
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      overrunFlag <= 1'b0;
      txPend <= 1'b0;
      txArmQ <= 1'b0;
      xoffPend <= 1'b0;
      flowPend <= 1'b0;
      rtsNQ <= 1'b1; // Match idle high pins
      ctsQ <= 1'b1;
      sleepEnable <= 1'b0;
      irq <= 1'b0;
    end else begin
      rtsNQ <= rtsN;
      ctsQ <= ctsSync2;
      txArmQ <= txCond & effMask[1];
      sleepEnable <= effMask[4];
      if (rxOverrun) begin
        overrunFlag <= 1'b1;
      end else if (rdLsr) begin
        overrunFlag <= 1'b0;
      end
      if (txCond && effMask[1] && !txArmQ) begin
        txPend <= 1'b1;
      end else if (rdSrc || wrThr) begin
        txPend <= 1'b0;
      end
      if (xoffSeen) begin
        xoffPend <= 1'b1;
      end else if (rdSrc || xonSeen) begin
        xoffPend <= 1'b0;
      end
      if ((effMask[6] && enhanced_feature_control[`UIES_EFR_RTS] && rtsN && !rtsNQ) ||
          (effMask[7] && enhanced_feature_control[`UIES_EFR_CTS] && ctsSync2 && !ctsQ)) begin
        flowPend <= 1'b1;
      end else if (rdMsr) begin
        flowPend <= 1'b0;
      end
      irq <= lineInt | rxInt | txInt | modemInt | xoffInt | flowInt;
    end
  end

endmodule

// ===== inc/uies_defs.vh
// Purpose: constants of the interrupt mask and status block
// Assumes: three-bit register address, eight-bit data
// Notes: definitions only
`ifndef UIES_DEFS_VH
`define UIES_DEFS_VH
// Register addresses
`define UIES_A_DATA 3'h0
`define UIES_A_MASK 3'h1
`define UIES_A_SRC 3'h2
`define UIES_A_LCTL 3'h3
`define UIES_A_MCTL 3'h4
`define UIES_A_LSTAT 3'h5
`define UIES_A_MSTAT 3'h6
`define UIES_A_SCR 3'h7
// Enhanced map, line control key
`define UIES_A_EFR 3'h2
`define UIES_A_RES1 3'h4
`define UIES_A_RES2 3'h5
`define UIES_A_PAU1 3'h6
`define UIES_A_PAU2 3'h7
`define UIES_KEY 8'hBF
// Field positions
`define UIES_EFR_ENH 4
`define UIES_EFR_RTS 6
`define UIES_EFR_CTS 7
`define UIES_LCR_DIV 7
`define UIES_FCR_EN 0
`define UIES_FCR_RXR 1
`define UIES_FCR_TXR 2
// Reset value of every control register
`define UIES_RST8 8'h00
// Source register codes
`define UIES_SRC_NONE 6'h01
`define UIES_SRC_LINE 6'h06
`define UIES_SRC_RX 6'h04
`define UIES_SRC_TX 6'h02
`define UIES_SRC_MODEM 6'h00
`define UIES_SRC_XOFF 6'h10
`define UIES_SRC_FLOW 6'h20
// FIFO trigger levels
`define UIES_RXT0 7'h08
`define UIES_RXT1 7'h10
`define UIES_RXT2 7'h38
`define UIES_RXT3 7'h3C
`define UIES_TXT0 7'h08
`define UIES_TXT1 7'h10
`define UIES_TXT2 7'h20
`define UIES_TXT3 7'h38
`define UIES_TXT_PLAIN 7'h01
`endif

// ===== verif/uart_interrupt_enable_status_tb.sv
// Purpose: register-level bench of the mask and status block
// Assumes: datapath model on the far side
// Notes: inputs change on the falling edge
`timescale 1ns/10ps
module uart_interrupt_enable_status_tb;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg [2:0] busAddr = 3'h0;
  reg busRd = 1'b0;
  reg busWr = 1'b0;
  reg [7:0] busWrData = 8'h00;
  reg summarySelectN = 1'b1;
  reg [7:0] msrData = 8'h00;
  reg xoffSeen = 1'b0;
  reg xonSeen = 1'b0;
  reg rtsN = 1'b1;
  reg ctsN = 1'b1;
  reg [1:0] rdPulse = 2'h0;
  wire [7:0] busRdData, rxData, readySummary, line_control_reg, fifo_control_reg, enhanced_feature_control, thrData;
  wire [6:0] rxCount, txCount;
  wire [2:0] rxHeadErr;
  wire rxOverrun, rxFifoErr, rxPop, thrEmpty, tsrEmpty, thrWrite, sleepEnable, irq;
  wire rxFifoReset, txFifoReset, msrRead;
  integer n_errors = 0;
  integer checked = 0;
  always #10 clk_sys = ~clk_sys;
  uies_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .busAddr(busAddr), .busRd(busRd), .busWr(busWr),
    .busWrData(busWrData), .summarySelectN(summarySelectN), .busRdData(busRdData), .rxData(rxData),
    .rxCount(rxCount), .rxHeadErr(rxHeadErr), .rxOverrun(rxOverrun), .rxFifoErr(rxFifoErr), .rxPop(rxPop),
    .rxFifoReset(rxFifoReset), .txCount(txCount), .thrEmpty(thrEmpty), .tsrEmpty(tsrEmpty), .thrWrite(thrWrite),
    .thrData(thrData), .txFifoReset(txFifoReset), .msrData(msrData), .xoffSeen(xoffSeen), .xonSeen(xonSeen),
    .rtsN(rtsN), .ctsN(ctsN),
    .readySummary(readySummary), .msrRead(msrRead), .line_control_reg(line_control_reg), .modem_control_reg(), .fifo_control_reg(fifo_control_reg), .enhanced_feature_control(enhanced_feature_control), .dll(), .dlm(),
    .divisor_fraction_reg(), .resumeCharFirst(), .resumeCharSecond(), .pauseCharFirst(), .pauseCharSecond(),
    .sleepEnable(sleepEnable), .irq(irq));
  uies_dp_model i_dp (.clk_sys(clk_sys), .rxPop(rxPop), .thrWrite(thrWrite), .rxCount(rxCount),
    .rxHeadErr(rxHeadErr), .rxOverrun(rxOverrun), .rxFifoErr(rxFifoErr), .thrEmpty(thrEmpty),
    .tsrEmpty(tsrEmpty), .rxData(rxData), .txCount(txCount), .readySummary(readySummary));
  // Comparison, bus cycles and verdict
  task check(input [7:0] seen, input [7:0] want);
    begin
      checked = checked + 1;
      if (seen !== want) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(negedge clk_sys);
      busAddr = a;
      busWrData = d;
      busWr = 1'b1;
      @(negedge clk_sys);
      busWr = 1'b0;
    end
  endtask
  task rd(input [2:0] a, input [7:0] want);
    begin
      @(negedge clk_sys);
      busAddr = a;
      busRd = 1'b1;
      @(negedge clk_sys);
      busRd = 1'b0;
      rdPulse = {rxPop, msrRead};
      @(negedge clk_sys);
      check(busRdData, want);
    end
  endtask
  task idle(input integer n);
    repeat (n) @(negedge clk_sys);
  endtask
  task conclude;
    begin
      if (n_errors == 0 && checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Watchdog
  initial begin
    repeat (4000) @(posedge clk_sys);
    n_errors = n_errors + 1;
    conclude;
  end
  // Main sequence
  initial begin
    idle(12);
    rst_n = 1'b1;
    rd(3'h1, 8'h00);
    rd(3'h2, 8'h01);
    rd(3'h5, 8'h60);
    wr(3'h2, 8'h31);
    check(fifo_control_reg, 8'h01);
    wr(3'h1, 8'hF2);
    rd(3'h1, 8'h02);
    check({7'h00, irq}, 8'h01);
    rd(3'h2, 8'hC2);
    idle(3);
    check({7'h00, irq}, 8'h00);
    rd(3'h2, 8'hC1);
    // Enhanced map behind the key
    wr(3'h3, 8'hBF);
    wr(3'h2, 8'h10);
    wr(3'h4, 8'hA5);
    wr(3'h5, 8'h5B);
    wr(3'h6, 8'h6C);
    wr(3'h7, 8'h7D);
    rd(3'h2, 8'h10);
    rd(3'h4, 8'hA5);
    rd(3'h5, 8'h5B);
    rd(3'h6, 8'h6C);
    rd(3'h7, 8'h7D);
    wr(3'h3, 8'h03);
    rd(3'h4, 8'h00);
    rd(3'h7, 8'h00);
    rd(3'h2, 8'hC1);
    wr(3'h4, 8'hE5);
    rd(3'h4, 8'hE5);
    // Polled mode: upper mask bits only
    wr(3'h1, 8'h10);
    rd(3'h1, 8'h10);
    check({7'h00, sleepEnable}, 8'h01);
    i_dp.rxCount = 7'h07;
    idle(3);
    check({7'h00, irq}, 8'h00);
    rd(3'h5, 8'h61);
    // Receive trigger crossing
    wr(3'h1, 8'h01);
    rd(3'h2, 8'hC1);
    i_dp.rxCount = 7'h08;
    idle(3);
    check({7'h00, irq}, 8'h01);
    rd(3'h2, 8'hC4);
    rd(3'h0, 8'h08);
    check({6'h00, rdPulse}, 8'h02);
    idle(3);
    check({7'h00, irq}, 8'h00);
    rd(3'h2, 8'hC1);
    // Overrun and head errors
    wr(3'h1, 8'h04);
    i_dp.rxOverrun = 1'b1;
    i_dp.rxHeadErr = 3'h5;
    i_dp.rxFifoErr = 1'b1;
    idle(1);
    i_dp.rxOverrun = 1'b0;
    idle(3);
    check({7'h00, irq}, 8'h01);
    rd(3'h2, 8'hC6);
    rd(3'h5, 8'hF7);
    i_dp.rxHeadErr = 3'h0;
    i_dp.rxFifoErr = 1'b0;
    rd(3'h5, 8'h61);
    // Transmit drain stages
    wr(3'h0, 8'h55);
    check({7'h00, thrWrite}, 8'h01);
    check(thrData, 8'h55);
    rd(3'h5, 8'h01);
    idle(2);
    rd(3'h5, 8'h21);
    idle(20);
    rd(3'h5, 8'h61);
    // Divisor latches and fraction register
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h12);
    wr(3'h1, 8'h34);
    wr(3'h2, 8'h05);
    rd(3'h0, 8'h12);
    check({6'h00, rdPulse}, 8'h00);
    rd(3'h1, 8'h34);
    rd(3'h2, 8'h05);
    wr(3'h3, 8'h03);
    // FIFO control with enhanced bits
    wr(3'h2, 8'h37);
    check({6'h00, rxFifoReset, txFifoReset}, 8'h03);
    check(fifo_control_reg, 8'h31);
    // Modem status source
    wr(3'h1, 8'h08);
    msrData = 8'h01;
    idle(3);
    check({7'h00, irq}, 8'h01);
    rd(3'h2, 8'hC0);
    rd(3'h6, 8'h01);
    check({6'h00, rdPulse}, 8'h01);
    msrData = 8'h00;
    idle(2);
    check({7'h00, irq}, 8'h00);
    // Pause character source, cleared by read or resume
    wr(3'h1, 8'h20);
    xoffSeen = 1'b1;
    idle(1);
    xoffSeen = 1'b0;
    idle(3);
    check({7'h00, irq}, 8'h01);
    rd(3'h2, 8'hD0);
    check({7'h00, irq}, 8'h00);
    xoffSeen = 1'b1;
    idle(1);
    xoffSeen = 1'b0;
    xonSeen = 1'b1;
    idle(1);
    xonSeen = 1'b0;
    idle(3);
    check({7'h00, irq}, 8'h00);
    // Rising request-to-send and clear-to-send
    wr(3'h3, 8'hBF);
    wr(3'h2, 8'hD0);
    wr(3'h3, 8'h03);
    wr(3'h1, 8'hC0);
    rtsN = 1'b0;
    idle(2);
    rtsN = 1'b1;
    idle(3);
    check({7'h00, irq}, 8'h01);
    rd(3'h2, 8'hE0);
    rd(3'h6, 8'h00);
    check({7'h00, irq}, 8'h00);
    ctsN = 1'b0;
    idle(4);
    ctsN = 1'b1;
    idle(5);
    check({7'h00, irq}, 8'h01);
    rd(3'h6, 8'h00);
    check({7'h00, irq}, 8'h00);
    // Reset in mid-run
    rst_n = 1'b0;
    idle(2);
    rst_n = 1'b1;
    rd(3'h1, 8'h00);
    rd(3'h2, 8'h01);
    // Summary select overrides address
    summarySelectN = 1'b0;
    idle(3);
    rd(3'h5, 8'h5A);
    summarySelectN = 1'b1;
    idle(3);
    conclude;
  end
endmodule

// ===== verif/uies_chk.sv
// Purpose: port checks of the mask and status block
// Assumes: bound to uies_top, one clock domain
// Notes: bit 1 of line status is sticky, so left out of field check
`timescale 1ns/10ps
module uies_chk (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Host port
  input wire [2:0] busAddr,
  input wire busRd,
  input wire busWr,
  input wire [7:0] busWrData,
  input wire summarySelectN,
  input wire [7:0] busRdData,
  // Status and controls
  input wire [6:0] rxCount,
  input wire [2:0] rxHeadErr,
  input wire rxFifoErr,
  input wire thrEmpty,
  input wire tsrEmpty,
  input wire [7:0] readySummary,
  input wire [7:0] line_control_reg,
  input wire [7:0] fifo_control_reg,
  input wire [7:0] enhanced_feature_control,
  input wire sleepEnable,
  input wire irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Reads behind a settled select pin, and the keyed feature write
  sequence s_lsrRd;
    summarySelectN [*3] ##0 (busRd && busAddr == 3'h5 && !line_control_reg[7]);
  endsequence
  sequence s_sumRd;
    !summarySelectN [*3] ##0 busRd;
  endsequence
  sequence s_efrWr;
    busWr && busAddr == 3'h2 && line_control_reg == 8'hBF;
  endsequence
  a_lsr_fields: assert property (s_lsrRd |=> busRdData[7:2] == {$past(rxFifoErr),
    $past(thrEmpty & tsrEmpty), $past(thrEmpty), $past(rxHeadErr)} && busRdData[0] == ($past(rxCount) != 7'h00))
    else $error("line status fields wrong");
  a_summary_read: assert property (s_sumRd |=> busRdData == $past(readySummary))
    else $error("summary read wrong");
  a_key_write: assert property (s_efrWr |=> enhanced_feature_control == $past(busWrData))
    else $error("keyed feature write lost");
  a_efr_locked: assert property (busWr && busAddr == 3'h2 && line_control_reg != 8'hBF |=> $stable(enhanced_feature_control))
    else $error("feature register changed without key");
  a_sleep_gate: assert property (!enhanced_feature_control[4] |=> !sleepEnable)
    else $error("sleep enabled outside enhanced mode");
  a_fcr_enh: assert property (busWr && busAddr == 3'h2 && !line_control_reg[7] && !enhanced_feature_control[4] |=> $stable(fifo_control_reg[5:4]))
    else $error("transmit trigger written outside enhanced mode");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !irq && enhanced_feature_control == 8'h00 && !sleepEnable)
    else $error("state not cleared by reset");
  a_read_hold: assert property (!busRd |=> $stable(busRdData))
    else $error("read data moved without read");
endmodule
bind uies_top uies_chk i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .busAddr(busAddr), .busRd(busRd),
  .busWr(busWr), .busWrData(busWrData), .summarySelectN(summarySelectN), .busRdData(busRdData),
  .rxCount(rxCount), .rxHeadErr(rxHeadErr), .rxFifoErr(rxFifoErr), .thrEmpty(thrEmpty),
  .tsrEmpty(tsrEmpty), .readySummary(readySummary), .line_control_reg(line_control_reg), .fifo_control_reg(fifo_control_reg), .enhanced_feature_control(enhanced_feature_control),
  .sleepEnable(sleepEnable), .irq(irq));

// ===== verif/uies_dp_model.sv
// Purpose: receive and transmit datapath seen by the block
// Assumes: changes at the falling edge of clk_sys
// Notes: bench sets fill and error fields; transmit drains slowly
`timescale 1ns/10ps
module uies_dp_model (
  // Clock
  input wire clk_sys,
  // Requests from the block
  input wire rxPop,
  input wire thrWrite,
  // Status to the block
  output reg [6:0] rxCount,
  output reg [2:0] rxHeadErr,
  output reg rxOverrun,
  output reg rxFifoErr,
  output wire thrEmpty,
  output wire tsrEmpty,
  output wire [7:0] rxData,
  output wire [6:0] txCount,
  output wire [7:0] readySummary
);
  reg [4:0] drain = 5'h00;
  initial begin
    rxCount = 7'h00;
    rxHeadErr = 3'h0;
    rxOverrun = 1'b0;
    rxFifoErr = 1'b0;
  end
  // Holding register frees before the shift register
  assign thrEmpty = drain < 5'h10;
  assign tsrEmpty = drain == 5'h00;
  assign txCount = {6'h00, !tsrEmpty};
  assign rxData = {1'b0, rxCount};
  assign readySummary = 8'h5A;
  // Pops and transmit drain
  always @(negedge clk_sys) begin
    if (rxPop && rxCount != 7'h00)
      rxCount <= rxCount - 7'h01;
    if (thrWrite)
      drain <= 5'h14;
    else if (drain != 5'h00)
      drain <= drain - 5'h01;
  end
endmodule
